// ===== rtl/acc_pkg.sv
// package for the converter control block: register map, fields, timing
// assumes an AXI4-Lite master with 32-bit data and byte addresses
package acc_pkg;
   localparam logic [7:0]  CTRL2_OFFSET     = 8'h08;
   localparam logic [7:0]  STATUS_OFFSET    = 8'h0c;
   localparam logic [31:0] CTRL2_RESET      = 32'h0000_0000;
   localparam logic [31:0] CTRL2_RW_MASK    = 32'h00fe_f90f;
   localparam int          TEMP_REF_BIT     = 23;
   localparam int          REG_SOFT_BIT     = 22;
   localparam int          INJ_SOFT_BIT     = 21;
   localparam int          REG_EXT_EN_BIT   = 20;
   localparam int          REG_SEL_LSB      = 17;
   localparam int          INJ_EXT_EN_BIT   = 15;
   localparam int          INJ_SEL_LSB      = 12;
   localparam int          ALIGN_BIT        = 11;
   localparam int          DMA_BIT          = 8;
   localparam int          CAL_RESET_BIT    = 3;
   localparam int          CAL_BIT          = 2;
   localparam int          CONTINUOUS_MODE_BIT         = 1;
   localparam int          POWER_BIT        = 0;
   localparam logic [2:0]  SEL_SOFTWARE     = 3'h7;
   localparam int          CLK_MHZ          = 25;
   localparam int          CAL_RESET_CYCLES = 8;
   localparam int          CAL_RESET_EXTRA  = 8;
   localparam int          CAL_CYCLES       = 83;
   localparam int          CONV_CYCLES      = 14;
   localparam int          CNT_W            = 8;
   typedef enum logic [1:0] {ACC_RESP_OKAY, ACC_RESP_EXOKAY, ACC_RESP_SLVERR,
                             ACC_RESP_DECERR} acc_resp_e;
endpackage

// ===== rtl/acc_trig_mux.sv
// trigger selector: picks one timer/line event for a group per instance
// assumes event inputs are already synchronised to aclk
`timescale 1ns/1ps
`default_nettype none
module acc_trig_mux
   import acc_pkg::*;
#(
   parameter int INSTANCE = 1,
   parameter bit INJECTED = 0
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [6:0] events,
   input  wire logic [2:0] select,
   output logic            edge_pulse
);
   if (INSTANCE < 1 || INSTANCE > 3) begin : g_bad_instance
      $error("instance must be 1 to 3");
   end
   logic sel_lvl;
   logic prev_reg;
   // events bus is wired by the top per instance, so one index picks the source
   always_comb begin
      sel_lvl = (select == SEL_SOFTWARE) ? 1'b0 : events[select];
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) prev_reg <= 1'b0;
      else prev_reg <= sel_lvl;
   end
   // rising edge only; a held level must not retrigger
   assign edge_pulse = sel_lvl & ~prev_reg;
endmodule
`default_nettype wire

// ===== rtl/acc_seq_timer.sv
// down counter that times calibration and calibration reset phases
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module acc_seq_timer
   import acc_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] count,
   input  wire logic             abort,
   output logic                  done
);
   logic [CNT_W-1:0] cnt_reg;
   logic             run_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn || abort) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= count;
         run_reg <= 1'b1;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 1'b1;
         if (cnt_reg == 1) run_reg <= 1'b0;
      end
   end
   assign done = run_reg && cnt_reg == 1 && !load && !abort;
endmodule
`default_nettype wire

// ===== rtl/acc_ctrl.sv
// converter control register with trigger, power, calibration sequencing
// assumes timer events arrive from other clock domains and are synchronised here
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - temp/reference channel enable bit 23, instance one
// - regular soft start bit, self-cleared at start
// - injected soft start bit, cleared at start
// - bit 20 gates regular external trigger
// - regular select map, instances one and two
// - regular select map, instance three
// - bit 15 gates injected external trigger
// - injected select map, instances one and two
// - injected select map, instance three
// - bit 8 DMA mode; instance two never requests
// - calibration reset bit clears when done
// - calibration reset during conversion takes longer
// - calibration bit held while calibrating
// - continuous mode repeats conversions until cleared
// - power-on from zero only wakes
// - power-on rewrite while on starts conversion
// - power-off stops conversion and calibration
// - power-on write with other changes: no start
module acc_ctrl
   import acc_pkg::*;
#(
   parameter int INSTANCE = 1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [6:0]  regular_events,
   input  wire logic [6:0]  injected_events,
   input  wire logic        conv_done,
   output logic             converter_power_on,
   output logic             regular_start,
   output logic             injected_start,
   output logic             calibrating,
   output logic             calibration_clearing,
   output logic             temp_ref_channel_enable,
   output logic             left_align,
   output logic             dma_enable,
   output logic             converting
);
   if (INSTANCE < 1 || INSTANCE > 3) begin : g_bad_instance
      $error("instance must be 1 to 3");
   end

   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_fire;
   logic        wr_hit;
   logic        conv_reg;
   logic        cal_run_reg;
   logic        rst_run_reg;
   logic [6:0]  reg_sync1_reg;
   logic [6:0]  reg_sync2_reg;
   logic [6:0]  inj_sync1_reg;
   logic [6:0]  inj_sync2_reg;
   logic        reg_ext_pulse;
   logic        inj_ext_pulse;
   logic        reg_go;
   logic        inj_go;
   logic        power_start;
   logic        cal_done;
   logic        rst_done;
   logic        cal_load;
   logic        rst_load;
   logic [CNT_W-1:0] rst_count;
   logic        power_drop;
   logic        reg_soft_set;
   logic        inj_soft_set;

   // timer events come from other domains: two flops before any use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reg_sync1_reg <= '0;
         reg_sync2_reg <= '0;
         inj_sync1_reg <= '0;
         inj_sync2_reg <= '0;
      end else begin
         reg_sync1_reg <= regular_events;
         reg_sync2_reg <= reg_sync1_reg;
         inj_sync1_reg <= injected_events;
         inj_sync2_reg <= inj_sync1_reg;
      end
   end

   // the top wires each instance's sources in select order
   acc_trig_mux #(.INSTANCE(INSTANCE), .INJECTED(1'b0)) u_reg_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .events     (reg_sync2_reg),
      .select     (ctrl_reg[REG_SEL_LSB +: 3]),
      .edge_pulse (reg_ext_pulse)
   );
   acc_trig_mux #(.INSTANCE(INSTANCE), .INJECTED(1'b1)) u_inj_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .events     (inj_sync2_reg),
      .select     (ctrl_reg[INJ_SEL_LSB +: 3]),
      .edge_pulse (inj_ext_pulse)
   );

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         awaddr_reg   <= '0;
         wdata_reg    <= '0;
         wstrb_reg    <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // readies are registered copies of what the holds and bvalid become
         s_axi_awready <= !wr_fire && !(s_axi_bvalid && !s_axi_bready)
                          && !(aw_hold_reg || (s_axi_awvalid && s_axi_awready));
         s_axi_wready  <= !wr_fire && !(s_axi_bvalid && !s_axi_bready)
                          && !(w_hold_reg || (s_axi_wvalid && s_axi_wready));
      end
   end
   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wr_hit  = awaddr_reg[7:2] == CTRL2_OFFSET[7:2];

   // proposed register value after byte strobes, writable bits only
   always_comb begin
      ctrl_next = ctrl_reg;
      for (int b = 0; b < 4; b++) begin
         if (wstrb_reg[b]) ctrl_next[b*8 +: 8] = wdata_reg[b*8 +: 8];
      end
      ctrl_next = ctrl_next & CTRL2_RW_MASK;
      if (INSTANCE != 1) ctrl_next[TEMP_REF_BIT] = 1'b0;
   end

   // start only when power was already on and nothing else changes
   assign power_start = wr_fire && wr_hit && ctrl_reg[POWER_BIT] && ctrl_next[POWER_BIT]
                        && (ctrl_next[31:1] == ctrl_reg[31:1]);
   assign reg_go = ctrl_reg[POWER_BIT] && !cal_run_reg && !rst_run_reg &&
                   ((ctrl_reg[REG_SOFT_BIT] && ctrl_reg[REG_SEL_LSB +: 3] == SEL_SOFTWARE)
                    || (ctrl_reg[REG_EXT_EN_BIT] && reg_ext_pulse)
                    || power_start
                    || (ctrl_reg[CONTINUOUS_MODE_BIT] && conv_done));
   assign inj_go = ctrl_reg[POWER_BIT] && !cal_run_reg && !rst_run_reg &&
                   ((ctrl_reg[INJ_SOFT_BIT] && ctrl_reg[INJ_SEL_LSB +: 3] == SEL_SOFTWARE)
                    || (ctrl_reg[INJ_EXT_EN_BIT] && inj_ext_pulse));

   // a power-off write ends every phase at the same edge as the bit drops
   assign power_drop   = wr_fire && wr_hit && !ctrl_next[POWER_BIT];
   // a fresh software request landing in the clearing cycle beats the clear
   assign reg_soft_set = wr_fire && wr_hit && ctrl_next[REG_SOFT_BIT];
   assign inj_soft_set = wr_fire && wr_hit && ctrl_next[INJ_SOFT_BIT];
   assign cal_load  = wr_fire && wr_hit && ctrl_next[CAL_BIT] && !cal_run_reg
                      && ctrl_reg[POWER_BIT] && ctrl_next[POWER_BIT];
   assign rst_load  = wr_fire && wr_hit && ctrl_next[CAL_RESET_BIT] && !rst_run_reg
                      && ctrl_reg[POWER_BIT] && ctrl_next[POWER_BIT];
   // reset during a conversion needs extra cycles
   assign rst_count = CNT_W'(CAL_RESET_CYCLES + (conv_reg ? CAL_RESET_EXTRA : 0));

   acc_seq_timer u_cal_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (cal_load),
      .count   (CNT_W'(CAL_CYCLES)),
      .abort   (!ctrl_reg[POWER_BIT] || power_drop),
      .done    (cal_done)
   );
   acc_seq_timer u_rst_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (rst_load),
      .count   (rst_count),
      .abort   (!ctrl_reg[POWER_BIT] || power_drop),
      .done    (rst_done)
   );

   // control register: software writes, hardware clears self-clearing bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CTRL2_RESET;
      end else begin
         if (wr_fire && wr_hit) begin
            ctrl_reg <= ctrl_next;
            // busy bits stay high while hardware works; software drops them only with a power-off write
            if (cal_run_reg) ctrl_reg[CAL_BIT] <= 1'b1;
            if (rst_run_reg) ctrl_reg[CAL_RESET_BIT] <= 1'b1;
            if (!ctrl_next[POWER_BIT]) begin
               ctrl_reg[CAL_BIT]       <= 1'b0;
               ctrl_reg[CAL_RESET_BIT] <= 1'b0;
            end
         end
         if (reg_go && !reg_soft_set) ctrl_reg[REG_SOFT_BIT] <= 1'b0;
         if (inj_go && !inj_soft_set) ctrl_reg[INJ_SOFT_BIT] <= 1'b0;
         if (cal_done) ctrl_reg[CAL_BIT] <= 1'b0;
         if (rst_done) ctrl_reg[CAL_RESET_BIT] <= 1'b0;
      end
   end

   // calibration and reset flags follow the timers; the conversion flag follows starts and conv_done
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_reg[POWER_BIT] || power_drop) begin
         cal_run_reg <= 1'b0;
         rst_run_reg <= 1'b0;
         conv_reg    <= 1'b0;
      end else begin
         if (cal_load) cal_run_reg <= 1'b1;
         else if (cal_done) cal_run_reg <= 1'b0;
         if (rst_load) rst_run_reg <= 1'b1;
         else if (rst_done) rst_run_reg <= 1'b0;
         if (reg_go || inj_go) conv_reg <= 1'b1;
         else if (conv_done) conv_reg <= 1'b0;
      end
   end

   // outputs to the analog core, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_power_on      <= 1'b0;
         regular_start           <= 1'b0;
         injected_start          <= 1'b0;
         calibrating             <= 1'b0;
         calibration_clearing    <= 1'b0;
         temp_ref_channel_enable <= 1'b0;
         left_align              <= 1'b0;
         dma_enable              <= 1'b0;
         converting              <= 1'b0;
      end else begin
         converter_power_on      <= ctrl_reg[POWER_BIT];
         regular_start           <= reg_go;
         injected_start          <= inj_go;
         calibrating             <= cal_run_reg;
         calibration_clearing    <= rst_run_reg;
         temp_ref_channel_enable <= ctrl_reg[TEMP_REF_BIT];
         left_align              <= ctrl_reg[ALIGN_BIT];
         dma_enable              <= ctrl_reg[DMA_BIT] && INSTANCE != 2;
         converting              <= conv_reg;
      end
   end

   // read channel: one-cycle turnaround, data from register or phase status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= 2'h0;
      end else begin
         // registered ready: low while a read answer is outstanding
         s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !(s_axi_rvalid && !s_axi_rready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ACC_RESP_OKAY;
            if (s_axi_araddr[7:2] == CTRL2_OFFSET[7:2]) begin
               s_axi_rdata <= ctrl_reg;
            end else if (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]) begin
               s_axi_rdata <= {29'h0, rst_run_reg, cal_run_reg, conv_reg};
            end else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= ACC_RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   AST_SOFT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      (reg_go && !reg_soft_set) |=> !ctrl_reg[REG_SOFT_BIT])
      else $error("regular soft start not cleared");
   AST_INJ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      (inj_go && !inj_soft_set) |=> !ctrl_reg[INJ_SOFT_BIT])
      else $error("injected soft start not cleared");
   AST_WAKE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_hit && !ctrl_reg[POWER_BIT]) |-> !power_start)
      else $error("wake write started conversion");
   AST_OTHER_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_hit && ctrl_next[31:1] != ctrl_reg[31:1]) |-> !power_start)
      else $error("changed write started conversion");
   AST_POWER_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_reg[POWER_BIT] |=> !cal_run_reg && !conv_reg)
      else $error("work continues while off");
   AST_CAL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_run_reg |-> ctrl_reg[CAL_BIT]) else $error("cal bit dropped early");
   AST_RST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      rst_run_reg |-> ctrl_reg[CAL_RESET_BIT]) else $error("cal reset dropped early");
   AST_NO_DMA_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
      INSTANCE == 2 |-> !dma_enable) else $error("instance two DMA");
   AST_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 left_align == $past(ctrl_reg[ALIGN_BIT])) else $error("alignment mismatch");
   AST_REG_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
      (reg_ext_pulse && !ctrl_reg[REG_EXT_EN_BIT] && !ctrl_reg[REG_SOFT_BIT]
       && !ctrl_reg[CONTINUOUS_MODE_BIT] && !power_start) |-> !reg_go)
      else $error("ungated regular trigger");
   AST_AW_READY: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> s_axi_awready == (!aw_hold_reg && !s_axi_bvalid))
      else $error("write address ready out of step");
   AST_W_READY: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> s_axi_wready == (!w_hold_reg && !s_axi_bvalid))
      else $error("write data ready out of step");
   AST_AR_READY: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> s_axi_arready == !s_axi_rvalid)
      else $error("read address ready out of step");
   AST_POWER_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
      power_drop |=> !cal_run_reg && !rst_run_reg && !conv_reg)
      else $error("phase survived power-off write");
endmodule
`default_nettype wire

// ===== test/acc_core_model.sv
// behavioural analog core: answers each start with one end-of-conversion pulse
// assumes single-cycle start pulses on aclk; DELAY sets how slowly it answers
`timescale 1ns/1ps
`default_nettype none
module acc_core_model
#(
   parameter int DELAY = 40
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic converter_power_on,
   input  wire logic regular_start,
   input  wire logic injected_start,
   output logic      conv_done
);
   int cnt_reg;

   // power-down drops any conversion in flight, so no late end pulse leaks out
   always_ff @(posedge aclk) begin
      if (!aresetn || !converter_power_on) begin
         cnt_reg   <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= (cnt_reg == 1);
         if (regular_start || injected_start) begin
            cnt_reg <= DELAY;
         end else if (cnt_reg != 0) begin
            cnt_reg <= cnt_reg - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/adc_conversion_control_tb.sv
// self-checking bench for the converter control register block
// assumes the core model answers starts; timer events are driven here
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
   import acc_pkg::*;
   localparam int         CORE_DELAY = 40;
   localparam int         STAB       = 20;
   localparam logic [1:0] OK         = ACC_RESP_OKAY;
   localparam logic [1:0] ERR        = ACC_RESP_SLVERR;
   localparam logic [7:0] A          = CTRL2_OFFSET;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [6:0]  rev = 7'h00, iev = 7'h00;
   logic        conv_done, pwr, rst, ist, cal, clr, tre, lal, dma, conv;
   wire  [4:0]  mon = {clr, cal, conv, ist, rst};
   int          bad_count = 0, samples_checked = 0, waited;
   int          pulses [2] = '{0, 0}, taken [2] = '{0, 0};

   // start pulses last one cycle and often fall inside a bus call: count them
   always @(posedge aclk) begin
      if (rst === 1'b1) pulses[0] <= pulses[0] + 1;
      if (ist === 1'b1) pulses[1] <= pulses[1] + 1;
   end

   acc_ctrl #(.INSTANCE(1)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .regular_events(rev), .injected_events(iev), .conv_done(conv_done),
      .converter_power_on(pwr), .regular_start(rst), .injected_start(ist),
      .calibrating(cal), .calibration_clearing(clr), .temp_ref_channel_enable(tre),
      .left_align(lal), .dma_enable(dma), .converting(conv));
   acc_core_model #(.DELAY(CORE_DELAY)) core (.aclk(aclk), .aresetn(aresetn),
      .converter_power_on(pwr), .regular_start(rst), .injected_start(ist),
      .conv_done(conv_done));

   always #20 aclk = ~aclk;

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   task automatic tmo(input string nm);
      $display("FAIL %s expected response seen timeout", nm);
      bad_count++;
      results();
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tk;
      logic [1:0] r;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tk = bvalid & bready;
         r  = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tk) begin
            bready <= 1'b0;
            chk("bresp", {30'h0, er}, {30'h0, r});
            return;
         end
      end
      tmo("write");
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tk;
      logic [1:0] r;
      logic [31:0] d;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tk = rvalid & rready;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tk) begin
            rready <= 1'b0;
            chk("rdata", e, d);
            chk("rresp", {30'h0, er}, {30'h0, r});
            return;
         end
      end
      tmo("read");
   endtask

   // mon index: 0 regular start, 1 injected start, 2 converting, 3 calibrating, 4 cal clear
   task automatic wait_for(input int idx, input logic v, input int lim, input string nm);
      for (waited = 1; waited <= lim; waited++) begin
         @(negedge aclk);
         if (idx < 2 && v === 1'b1) begin
            if (pulses[idx] > taken[idx]) begin
               taken[idx] = pulses[idx];
               samples_checked++;
               return;
            end
         end else if (mon[idx] === v) begin
            samples_checked++;
            return;
         end
      end
      tmo(nm);
   endtask

   task automatic quiet(input int idx, input int n, input string nm);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge aclk);
         if (mon[idx] !== 1'b0) seen = 1'b1;
      end
      if (idx < 2 && pulses[idx] != taken[idx]) seen = 1'b1;
      if (idx < 2) taken[idx] = pulses[idx];
      chk(nm, 32'h0, {31'h0, seen});
   endtask

   task automatic ev(input int g, input int c, input logic v);
      @(posedge aclk);
      if (g == 1) iev[c] <= v;
      else rev[c] <= v;
   endtask

   task automatic sc_regs;
      axr(A, CTRL2_RESET, OK);
      axr(8'h40, 32'h0, ERR);
      axw(8'h40, 32'hffff_ffff, ERR);
      axw(A, 32'hff9f_fff2, OK);
      axr(A, 32'h009e_f902, OK);
      chk("outputs on", 32'he, {28'h0, tre, lal, dma, pwr});
      axw(A, 32'h0, OK);
      axr(A, 32'h0, OK);
      chk("outputs off", 32'h0, {28'h0, tre, lal, dma, pwr});
   endtask

   task automatic sc_power;
      axw(A, 32'h1, OK);
      quiet(0, 10, "start on wake");
      repeat (STAB) @(posedge aclk);
      axw(A, 32'h1, OK);
      wait_for(0, 1'b1, 10, "start on rewrite");
      wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
      axw(A, 32'h0000_0801, OK);
      quiet(0, 10, "start with other change");
      axw(A, 32'h1, OK);
   endtask

   task automatic sc_soft;
      axw(A, 32'h004e_0001, OK);
      wait_for(0, 1'b1, 10, "regular soft start");
      axr(A, 32'h000e_0001, OK);
      wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
      axw(A, 32'h0020_7001, OK);
      wait_for(1, 1'b1, 10, "injected soft start");
      axr(A, 32'h0000_7001, OK);
      wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
   endtask

   task automatic sc_trig;
      for (int g = 0; g < 2; g++) begin
         for (int c = 0; c < 7; c++) begin
            axw(A, (g == 1) ? (32'h0000_8001 | (c << 12)) : (32'h0010_0001 | (c << 17)), OK);
            ev(g, (c + 1) % 7, 1'b1);
            quiet(g, 8, "unselected event");
            ev(g, (c + 1) % 7, 1'b0);
            ev(g, c, 1'b1);
            wait_for(g, 1'b1, 10, "selected event start");
            ev(g, c, 1'b0);
            wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
         end
         axw(A, 32'h1, OK);
         ev(g, 0, 1'b1);
         quiet(g, 10, "gated event");
         ev(g, 0, 1'b0);
      end
   endtask

   task automatic sc_continuous_mode;
      axw(A, 32'h004e_0003, OK);
      wait_for(0, 1'b1, 10, "continuous first start");
      wait_for(0, 1'b0, 3, "start pulse end");
      wait_for(0, 1'b1, CORE_DELAY + 20, "continuous restart");
      axw(A, 32'h000e_0001, OK);
      wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
      quiet(0, CORE_DELAY + 20, "single mode restart");
   endtask

   task automatic sc_cal;
      int t1;
      axw(A, 32'h5, OK);
      wait_for(3, 1'b1, 5, "calibration begins");
      axr(A, 32'h5, OK);
      wait_for(3, 1'b0, CAL_CYCLES + 10, "calibration ends");
      chk("calibration length", 32'h1, {31'h0, waited >= CAL_CYCLES - 6});
      axr(A, 32'h1, OK);
      axw(A, 32'h9, OK);
      wait_for(4, 1'b1, 5, "cal reset begins");
      wait_for(4, 1'b0, 40, "cal reset ends");
      t1 = waited;
      axr(A, 32'h1, OK);
      axw(A, 32'h004e_0001, OK);
      wait_for(2, 1'b1, 10, "conversion begins");
      axw(A, 32'h000e_0009, OK);
      wait_for(4, 1'b1, 5, "busy cal reset begins");
      wait_for(4, 1'b0, 60, "busy cal reset ends");
      chk("busy cal reset longer", 32'h1, {31'h0, waited > t1});
      wait_for(2, 1'b0, CORE_DELAY + 20, "conversion end");
      axw(A, 32'h5, OK);
      wait_for(3, 1'b1, 5, "calibration begins");
      axw(A, 32'h0, OK);
      wait_for(3, 1'b0, 4, "calibration stopped");
      axr(A, 32'h0, OK);
      axw(A, 32'h1, OK);
      repeat (STAB) @(posedge aclk);
      axw(A, 32'h004e_0001, OK);
      wait_for(2, 1'b1, 10, "conversion begins");
      axw(A, 32'h0, OK);
      wait_for(2, 1'b0, 4, "conversion stopped");
      chk("power off", 32'h0, {31'h0, pwr});
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      sc_regs();
      sc_power();
      sc_soft();
      sc_trig();
      sc_continuous_mode();
      sc_cal();
      results();
   end
endmodule
`default_nettype wire
